// >>> rtl/ulpi_phy_port.sv
// What this block does
// [RL1] Drive interface clock; all outputs registered (data_oe is decoded from st_r and hold_low_s)
// [RL2] Eight-bit shared bus, bit 7 MSB
// [RL3] Raise direction when data waits for link
// [RL4] Direction low when idle; watch bus
// [RL5] Next pulse marks link byte taken
// [RL6] Link gives next byte cycle after
// [RL7] Link stop lasts exactly one cycle
// [RL8] Stop means last byte came before
// [RL9] Hold low suspends and floats pins
// [RL10] Supply enable high-active, low after reset
// [RL11] System supplies reference clock input
// [RL12] Link releases bus while direction high
`include "ulpi_cfg.svh"

module ulpi_phy_port (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Pins from the link side
    input  wire logic            chip_hold_low_n,
    input  wire logic            reference_clock_in,
    input  wire logic            stp,
    input  wire logic [7:0]      data_in,
    // Pins toward the link side
    output logic [7:0]           data_out,
    output logic [7:0]           data_oe,
    output logic                 dir,
    output logic                 dir_oe,
    output logic                 nxt,
    output logic                 nxt_oe,
    output logic                 interface_clock_output,
    output logic                 interface_clock_oe,
    output logic                 vbus_supply_enable,
    output logic                 vbus_supply_oe,
    // Core: bytes to send to the link
    input  wire logic            tx_valid,
    output logic                 tx_ready,
    input  ulpi_pkg::beat_t      tx_beat,
    // Core: bytes received from the link
    output logic                 rx_valid,
    input  wire logic            rx_ready,
    output ulpi_pkg::beat_t      rx_beat,
    // Core: supply control and status
    input  wire logic            vbus_request,
    output logic                 suspended,
    output logic                 ref_clock_seen
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [10:0] sync1_r;
    logic [10:0] sync2_r;
    logic [10:0] sync1_nxt;

    always_comb begin
        sync1_nxt = {chip_hold_low_n, reference_clock_in, stp, data_in};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync1_r;
        end
    end

    logic                hold_low_s;
    logic                reference_clock_in_s;
    logic                stp_s;
    ulpi_pkg::byte_t     din_s;

    // [RL2] Bit order kept
    assign din_s      = sync2_r[`DATA_MSB:`DATA_LSB];
    assign stp_s      = sync2_r[8];
    assign reference_clock_in_s   = sync2_r[9];
    assign hold_low_s = ~sync2_r[10];

    // ********************************************************
    // Reference clock presence and interface clock
    // ********************************************************
    logic                 ref_prev_r;
    logic                 ref_seen_r;
    logic                 ref_prev_nxt;
    logic                 ref_seen_nxt;
    logic [`IFC_CNT_W-1:0] div_r;
    logic [`IFC_CNT_W-1:0] div_nxt;
    logic                 ifc_r;
    logic                 ifc_nxt;

    // [RL11] Reference edge detect
    always_comb begin
        ref_prev_nxt = reference_clock_in_s;
        ref_seen_nxt = ref_seen_r | (reference_clock_in_s & ~ref_prev_r);
        div_nxt      = div_r + `IFC_CNT_W'(1);
        ifc_nxt      = ifc_r;
        // [RL1] Clock output divider
        if (div_r == `IFC_CNT_W'(`IFC_HALF_CYC - 1)) begin
            div_nxt = '0;
            ifc_nxt = ~ifc_r;
        end
        if (hold_low_s) begin
            ref_seen_nxt = 1'b0;
            ifc_nxt      = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_prev_r <= 1'b0;
            ref_seen_r <= 1'b0;
            div_r      <= '0;
            ifc_r      <= 1'b0;
        end else begin
            ref_prev_r <= ref_prev_nxt;
            ref_seen_r <= ref_seen_nxt;
            div_r      <= div_nxt;
            ifc_r      <= ifc_nxt;
        end
    end

    // ********************************************************
    // Outbound buffer
    // ********************************************************
    logic            ob_valid;
    logic            ob_ready;
    ulpi_pkg::beat_t ob_beat;

    beat_buffer u_tx_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_beat   (tx_beat),
        .out_valid (ob_valid),
        .out_ready (ob_ready),
        .out_beat  (ob_beat)
    );

    // ********************************************************
    // Bus ownership and transfers
    // ********************************************************
    ulpi_pkg::bus_state_t st_r;
    ulpi_pkg::bus_state_t st_nxt;
    logic                 dir_r;
    logic                 dir_nxt;
    logic                 nxt_r;
    logic                 nxt_nxt;
    ulpi_pkg::beat_t      dout_r;
    ulpi_pkg::beat_t      dout_nxt;
    logic [4:0]           lag_r;
    logic [4:0]           lag_nxt;
    logic                 stop_r;
    logic                 stop_nxt;
    ulpi_pkg::byte_t      hold_r;
    ulpi_pkg::byte_t      hold_nxt;
    logic                 hold_v_r;
    logic                 hold_v_nxt;
    logic                 rx_in_valid;
    ulpi_pkg::beat_t      rx_in_beat;
    logic                 rx_in_ready;
    logic                 vbus_r;
    logic                 vbus_nxt;

    always_comb begin
        st_nxt      = st_r;
        dir_nxt     = dir_r;
        nxt_nxt     = 1'b0;
        dout_nxt    = dout_r;
        hold_nxt    = hold_r;
        hold_v_nxt  = hold_v_r;
        ob_ready    = 1'b0;
        rx_in_valid = 1'b0;
        rx_in_beat  = '{data: hold_r, last: 1'b0};
        vbus_nxt    = vbus_request;
        // Synchronised bus bytes lag the pins, so recent direction and next history gates them.
        lag_nxt     = {lag_r[3:2], nxt_r, lag_r[0], dir_r};
        stop_nxt    = stop_r;
        case (st_r)
            ulpi_pkg::ST_IDLE: begin
                // [RL5] Take link byte
                if (din_s != `BYTE_RST && !hold_v_r && rx_in_ready && !stp_s && lag_r[1:0] == 2'h0) begin
                    hold_nxt   = din_s;
                    hold_v_nxt = 1'b1;
                    nxt_nxt    = 1'b1;
                end
                // [RL8] Stop closes stream
                if ((stp_s || stop_r) && hold_v_r) begin
                    stop_nxt = !rx_in_ready;
                    if (rx_in_ready) begin
                        rx_in_valid = 1'b1;
                        rx_in_beat  = '{data: hold_r, last: 1'b1};
                        hold_v_nxt  = 1'b0;
                    end
                end else if (hold_v_r && !nxt_r && lag_r[4:2] == 3'h0 && din_s != `BYTE_RST && rx_in_ready) begin
                    // [RL6] Next byte follows
                    rx_in_valid = 1'b1;
                    hold_nxt    = din_s;
                    nxt_nxt     = 1'b1;
                end
                // [RL3] Take ownership
                if (ob_valid && !hold_v_nxt && !nxt_r) begin
                    st_nxt  = ulpi_pkg::ST_TURN_OUT;
                    dir_nxt = 1'b1;
                end
            end
            ulpi_pkg::ST_TURN_OUT: begin
                ob_ready = 1'b1;
                dout_nxt = ob_beat;
                st_nxt   = ulpi_pkg::ST_SEND;
            end
            ulpi_pkg::ST_SEND: begin
                ob_ready = !dout_r.last;
                if (dout_r.last || !ob_valid) begin
                    st_nxt = ulpi_pkg::ST_TURN_IN;
                end else begin
                    dout_nxt = ob_beat;
                end
            end
            ulpi_pkg::ST_TURN_IN: begin
                // [RL4] Release bus
                dir_nxt = 1'b0;
                st_nxt  = ulpi_pkg::ST_IDLE;
            end
            default: begin
                st_nxt  = ulpi_pkg::ST_IDLE;
                dir_nxt = 1'b0;
            end
        endcase
        if (hold_low_s) begin
            st_nxt     = ulpi_pkg::ST_IDLE;
            dir_nxt    = 1'b0;
            nxt_nxt    = 1'b0;
            hold_v_nxt = 1'b0;
            stop_nxt   = 1'b0;
            vbus_nxt   = `VBUS_EN_RST;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r     <= ulpi_pkg::ST_IDLE;
            dir_r    <= 1'b0;
            nxt_r    <= 1'b0;
            dout_r   <= '{data: `BYTE_RST, last: 1'b0};
            hold_r   <= `BYTE_RST;
            hold_v_r <= 1'b0;
            lag_r    <= '0;
            stop_r   <= 1'b0;
            // [RL10] Supply off at reset
            vbus_r   <= `VBUS_EN_RST;
        end else begin
            st_r     <= st_nxt;
            dir_r    <= dir_nxt;
            nxt_r    <= nxt_nxt;
            dout_r   <= dout_nxt;
            hold_r   <= hold_nxt;
            hold_v_r <= hold_v_nxt;
            lag_r    <= lag_nxt;
            stop_r   <= stop_nxt;
            vbus_r   <= vbus_nxt;
        end
    end

    beat_buffer u_rx_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (rx_in_valid),
        .in_ready  (rx_in_ready),
        .in_beat   (rx_in_beat),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_beat  (rx_beat)
    );

    // ********************************************************
    // Pin drive
    // ********************************************************
    // Data is only driven in the send state, never on the turnaround cycles,
    // so the link has a whole cycle to release the bus.
    // [RL9] Float all when held
    always_comb begin
        data_out               = dout_r.data;
        data_oe                = {8{(st_r == ulpi_pkg::ST_SEND) && !hold_low_s}};
        dir                    = dir_r;
        dir_oe                 = !hold_low_s;
        nxt                    = nxt_r;
        nxt_oe                 = !hold_low_s;
        interface_clock_output = ifc_r;
        interface_clock_oe     = !hold_low_s;
        vbus_supply_enable     = vbus_r;
        vbus_supply_oe         = !hold_low_s;
    end

    assign suspended      = hold_low_s;
    assign ref_clock_seen = ref_seen_r;

endmodule

// >>> shared/ulpi_cfg.svh
`ifndef ULPI_CFG_SVH
`define ULPI_CFG_SVH

// Clock figures, in Hz.
`define SYS_CLK_HZ        20000000
`define IFC_CLK_HZ        60000000
`define REF_CLK_HZ        13000000
// Interface clock divider: half period in system cycles, at least one.
`define IFC_HALF_RAW      (`SYS_CLK_HZ / (2 * `IFC_CLK_HZ))
`define IFC_HALF_CYC      ((`IFC_HALF_RAW < 1) ? 1 : `IFC_HALF_RAW)
`define IFC_CNT_W         4
// Bus width and bit positions.
`define DATA_W            8
`define DATA_MSB          7
`define DATA_LSB          0
// Reset values and buffer depth.
`define VBUS_EN_RST       1'b0
`define BYTE_RST          8'h00
`define BUF_DEPTH         2

`endif

// >>> shared/ulpi_pkg.sv
`include "ulpi_cfg.svh"

package ulpi_pkg;

    typedef logic [`DATA_MSB:`DATA_LSB] byte_t;

    // One byte with its framing mark.
    typedef struct packed {
        byte_t data;
        logic  last;
    } beat_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TURN_OUT,
        ST_SEND,
        ST_TURN_IN
    } bus_state_t;

endpackage

// >>> rtl/beat_buffer.sv
`include "ulpi_cfg.svh"

module beat_buffer (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Filling side
    input  wire logic            in_valid,
    output logic                 in_ready,
    input  ulpi_pkg::beat_t      in_beat,
    // Draining side
    output logic                 out_valid,
    input  wire logic            out_ready,
    output ulpi_pkg::beat_t      out_beat
);

    ulpi_pkg::beat_t mem_r [`BUF_DEPTH];
    ulpi_pkg::beat_t mem_nxt [`BUF_DEPTH];
    logic            wp_r;
    logic            wp_nxt;
    logic            rp_r;
    logic            rp_nxt;
    logic [1:0]      cnt_r;
    logic [1:0]      cnt_nxt;
    logic            push;
    logic            pop;

    assign in_ready  = (cnt_r != 2'(`BUF_DEPTH));
    assign out_valid = (cnt_r != 2'h0);
    assign out_beat  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_beat;
            wp_nxt        = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `BUF_DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mem_r[gi] <= '0;
                end else begin
                    mem_r[gi] <= mem_nxt[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule

// >>> tb/ulpi_phy_port_properties.sv
// ****
// Port checker
// ****
module ulpi_phy_port_properties (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Core side
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input ulpi_pkg::beat_t rx_beat,
    input wire logic       vbus_request,
    input wire logic       suspended,
    // Pin side
    input wire logic [7:0] data_oe,
    input wire logic       dir,
    input wire logic       dir_oe,
    input wire logic       nxt,
    input wire logic       nxt_oe,
    input wire logic       interface_clock_output,
    input wire logic       interface_clock_oe,
    input wire logic       vbus_supply_enable,
    input wire logic       vbus_supply_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    clock_runs_a: assert property (
        !suspended && !$past(suspended) |-> interface_clock_output != $past(interface_clock_output))
        else $error("Interface clock failed to toggle.");
    pins_float_a: assert property (
        suspended && $past(suspended) |-> {data_oe, dir_oe, nxt_oe, interface_clock_oe, vbus_supply_oe} == 12'h000)
        else $error("Pin driven while suspended.");
    drive_owned_a: assert property (
        data_oe != 8'h00 |-> data_oe == 8'hff && dir)
        else $error("Bus driven without ownership.");
    turn_first_a: assert property (
        $rose(data_oe[0]) |-> $past(dir) && dir)
        else $error("Bus driven without turnaround cycle.");
    release_first_a: assert property (
        $fell(dir) |-> data_oe == 8'h00 && $past(data_oe) == 8'h00)
        else $error("Direction dropped while bus driven.");
    next_pulse_a: assert property (
        nxt |=> !nxt)
        else $error("Next held longer than one cycle.");
    supply_follow_a: assert property (
        vbus_supply_enable == ($past(vbus_request) && !$past(suspended)))
        else $error("Supply enable does not follow request.");
    own_quick_a: assert property (
        tx_valid && tx_ready && !suspended |-> ##[1:4] dir)
        else $error("Direction not raised for waiting byte.");
    rx_hold_a: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_beat))
        else $error("Received beat lost during stall.");
endmodule

bind ulpi_phy_port ulpi_phy_port_properties chk (
    .clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_beat(rx_beat), .vbus_request(vbus_request), .suspended(suspended),
    .data_oe(data_oe), .dir(dir), .dir_oe(dir_oe), .nxt(nxt), .nxt_oe(nxt_oe),
    .interface_clock_output(interface_clock_output), .interface_clock_oe(interface_clock_oe),
    .vbus_supply_enable(vbus_supply_enable), .vbus_supply_oe(vbus_supply_oe)
);

// >>> tb/link_model.sv
// ****
// Link controller model
// ****
module link_model (
    // Pins seen from the device
    input  wire logic clk,
    input  wire logic dir,
    input  wire logic nxt,
    // Pins toward the device
    output logic [7:0] link_data,
    output logic       link_oe,
    output logic       stp,
    output logic       reference_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        link_data = 8'h00;
        stp = 1'b0;
        reference_clock_in = 1'b0;
        forever #38.462 reference_clock_in = ~reference_clock_in;
    end

    assign link_oe = !dir;

    // A refused byte is held, so a full receive buffer only slows the packet.
    task automatic send(input ulpi_pkg::byte_t bytes[$]);
        int n;
        for (int i = 0; i < bytes.size(); i++) begin
            link_data = bytes[i];
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (nxt !== 1'b1 && n < 400);
            #2;
        end
        stp = 1'b1;
        link_data = 8'h00;
        @(posedge clk);
        #2;
        stp = 1'b0;
    endtask
endmodule

// >>> tb/ulpi_phy_port_tb.sv
module ulpi_phy_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clk, rst, chip_hold_low_n, ref_in, stp, ref_seen, suspended;
    logic [7:0]      data_in, data_out, data_oe, link_data, bus_last, lfsr;
    logic            dir, dir_oe, nxt, nxt_oe, ifc_clk, ifc_clk_oe, vbus_en, vbus_oe, link_oe;
    logic            tx_valid, tx_ready, rx_valid, rx_ready, rx_hold, vbus_request, prev;
    ulpi_pkg::beat_t tx_beat, rx_beat;
    int              failures, compares, refusals;
    ulpi_pkg::byte_t tx_exp[$], pkt[$];
    ulpi_pkg::beat_t rx_exp[$];

    // A released bus shows the inverse of its last value, never a convenient zero.
    assign data_in = data_oe[0] ? data_out : (link_oe ? link_data : ~bus_last);

    ulpi_phy_port uut (
        .clk(clk), .rst(rst), .chip_hold_low_n(chip_hold_low_n), .reference_clock_in(ref_in), .stp(stp),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .dir(dir), .dir_oe(dir_oe), .nxt(nxt),
        .nxt_oe(nxt_oe), .interface_clock_output(ifc_clk), .interface_clock_oe(ifc_clk_oe),
        .vbus_supply_enable(vbus_en), .vbus_supply_oe(vbus_oe), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_beat(tx_beat), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat),
        .vbus_request(vbus_request), .suspended(suspended), .ref_clock_seen(ref_seen)
    );

    link_model link (
        .clk(clk), .dir(dir & dir_oe), .nxt(nxt & nxt_oe), .link_data(link_data), .link_oe(link_oe),
        .stp(stp), .reference_clock_in(ref_in)
    );

    function automatic logic [7:0] lfsr_step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic step();
        @(posedge clk);
        #2;
    endtask

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic tx_push(input ulpi_pkg::beat_t b);
        tx_valid = 1'b1;
        tx_beat = b;
        while (tx_ready !== 1'b1) begin
            refusals++;
            step();
        end
        tx_exp.push_back(b.data);
        step();
    endtask

    task automatic drain(input string name);
        int n;
        n = 0;
        while ((tx_exp.size() != 0 || rx_exp.size() != 0 || dir !== 1'b0) && n < 500) begin
            step();
            n++;
        end
        check({name, " drained"}, {8'h00, n < 500}, 9'h001);
        repeat (4) step();
        $display("Test %s finished", name);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****
    // Monitors and random receiver stall
    // ****
    always @(posedge clk) begin
        bus_last <= data_in;
        lfsr <= lfsr_step(lfsr);
        rx_ready <= #2 !rx_hold && lfsr[0];
        if (data_oe === 8'hff) begin
            if (tx_exp.size() == 0) check("tx unexpected", {1'b0, data_out}, {1'b1, ~data_out});
            else check("tx byte", {1'b0, data_out}, {1'b0, tx_exp.pop_front()});
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (rx_exp.size() == 0) check("rx unexpected", rx_beat, ~rx_beat);
            else check("rx beat", rx_beat, rx_exp.pop_front());
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    // ****
    // Main sequence
    // ****
    initial begin
        {rst, chip_hold_low_n} = 2'b11;
        {tx_valid, rx_hold, rx_ready, vbus_request} = 4'h0;
        {failures, compares, refusals} = 0;
        tx_beat = '0;
        bus_last = 8'h00;
        lfsr = 8'h19;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        repeat (8) step();
        check("dir idle", {8'h00, dir}, 9'h000);
        check("ref seen", {8'h00, ref_seen}, 9'h001);
        prev = ifc_clk;
        step();
        check("clock toggle", {7'h00, ifc_clk_oe, ifc_clk}, {7'h00, 1'b1, ~prev});
        vbus_request = 1'b1;
        step();
        check("supply", {7'h00, vbus_en, vbus_oe}, 9'h003);
        $display("Test idle finished");
        for (int i = 0; i < 8; i++) tx_push('{data: lfsr ^ 8'(i), last: i % 4 == 3});
        tx_valid = 1'b0;
        check("tx refused", {8'h00, refusals > 0}, 9'h001);
        drain("tx burst");
        for (int t = 0; t < 2; t++) begin
            pkt.delete();
            for (int i = 0; i < 3 + 2 * t; i++) begin
                pkt.push_back(lfsr | 8'h01);
                rx_exp.push_back('{data: lfsr | 8'h01, last: i == 2 + 2 * t});
                step();
            end
            rx_hold = (t == 1);
            fork
                link.send(pkt);
            join_none
            repeat (30) step();
            rx_hold = 1'b0;
            wait fork;
            drain("rx packet");
        end
        chip_hold_low_n = 1'b0;
        repeat (4) step();
        check("suspend", {suspended, |data_oe, dir_oe, nxt_oe, ifc_clk_oe, vbus_oe, vbus_en, 2'b00}, 9'h100);
        chip_hold_low_n = 1'b1;
        repeat (4) step();
        check("resume", {6'h00, suspended, dir_oe, vbus_en}, 9'h003);
        $display("Test suspend finished");
        tally_and_finish();
    end
endmodule
